// ### rtl/crf_register_file.v
// Programmer-visible register set of the 8-bit core with a bus slave port.
//
// Contract
// - Index pointer is upper byte over low byte, sixteen bits wide.
// - Indexed accesses use the full sixteen-bit pointer as base.
// - Low-byte operations change only the low byte of the pointer.
// - Reset clears the upper byte; the low byte keeps its value.
// - Stack pointer always addresses the next free stack location.
// - Stack adjust adds a sign-extended byte to the whole stack pointer.
// - Reset loads the stack pointer with 0x00FF.
// - Stack low-byte restore changes only the low stack byte.
// - Fetch location advances by one after each fetched byte.
// - Change of flow loads fetch location with the target address.
// - After reset fetch location holds the vector from the top bytes.
// - Flag bits 6 and 5 always read as one.
// - Overflow flag follows two's complement overflow of the result.
// - Half-carry flag follows carry from bit 3 into bit 4 on adds.
// - Decimal adjust corrects a BCD sum using half-carry and carry.
// - Mask bit set blocks maskable interrupts; clear allows them.
// - Mask bit is set after stacking, before the service routine.
// - No interrupt at the boundary right after the mask is cleared.
// - Negative flag copies the result or loaded value top bit.
// - Zero flag shows an all-zero result or loaded value.
// - Carry flag follows carry, borrow, shifts and bit tests; the flag unit has no bit-test kind.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_register_file (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire vec_req,
    output reg [15:0] vec_addr,
    input wire vec_valid,
    input wire [7:0] vec_data,
    output wire core_run,
    input wire fetch_step,
    input wire flow_load,
    input wire [15:0] flow_target,
    output reg [15:0] fetch_location,
    input wire idx_load16,
    input wire [15:0] idx_data16,
    input wire idx_load_low,
    input wire [7:0] idx_low_data,
    input wire idx_post_inc,
    output wire [15:0] index_base,
    input wire sp_load16,
    input wire [15:0] sp_data16,
    input wire sp_adjust,
    input wire [7:0] sp_imm8,
    input wire sp_low_restore,
    input wire sp_push,
    input wire sp_pull,
    output reg [15:0] stack_top_ptr,
    input wire [2:0] fu_kind,
    input wire [7:0] fu_opa,
    input wire [7:0] fu_opb,
    input wire fu_wide,
    input wire [15:0] fu_value16,
    input wire fu_shift_c,
    output reg [7:0] alu_result,
    output wire [7:0] flags_word,
    input wire mask_clear_op,
    input wire flags_from_accum_op,
    input wire [7:0] accum_data,
    input wire stack_done,
    input wire insn_boundary,
    input wire irq_pending,
    output wire irq_take
);
    // One-hot states of the reset vector fetch.
    localparam ST_VEC_HI = 3'b001;
    localparam ST_VEC_LO = 3'b010;
    localparam ST_RUN = 3'b100;

    reg [2:0] state;
    reg [7:0] pointer_upper_byte, pointer_low_byte, flags_store, wr_addr;
    reg mask_inhibit, wr_pend;
    reg [15:0] next_fetch, next_stack;
    reg [7:0] next_upper, next_low, next_flags;
    reg [31:0] next_rdata;
    wire [7:0] fu_result;
    wire fu_v, fu_h, fu_n, fu_z, fu_c;
    wire fu_we_v, fu_we_h, fu_we_c;
    wire addr_phase, mask_dropping;
    wire wr_index, wr_stack, wr_fetch, wr_flags;

    // The slave always answers at once with an OKAY response.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // A transfer is taken on a NONSEQ or SEQ address phase.
    assign addr_phase = hsel && hready && htrans[1];

    // Data phase write strobes, one per mapped word.
    assign wr_index = wr_pend && (wr_addr == `CRF_OFS_INDEX);
    assign wr_stack = wr_pend && (wr_addr == `CRF_OFS_STACK);
    assign wr_fetch = wr_pend && (wr_addr == `CRF_OFS_FETCH);
    assign wr_flags = wr_pend && (wr_addr == `CRF_OFS_FLAGS);

    // Index base is the full pointer pair, never the low byte alone.
    assign index_base = {pointer_upper_byte, pointer_low_byte};

    // Fixed bits are forced on the read path as well as in storage.
    assign flags_word = flags_store | `CRF_FIXED_ONES;

    assign core_run = (state == ST_RUN);
    assign vec_req = (state != ST_RUN);

    // An interrupt is taken only at a boundary, unmasked and not inhibited.
    assign irq_take = core_run && insn_boundary && irq_pending &&
        !flags_store[`CRF_BIT_I] && !mask_inhibit;

    // The mask goes from one to zero by a mask clear or a flags transfer.
    assign mask_dropping = flags_store[`CRF_BIT_I] &&
        (mask_clear_op ||
        (flags_from_accum_op && !accum_data[`CRF_BIT_I]));

    // Flag and result computation.
    crf_flag_unit u_flags (
        .kind(fu_kind),
        .opa(fu_opa),
        .opb(fu_opb),
        .cin(flags_store[`CRF_BIT_C]),
        .hin(flags_store[`CRF_BIT_H]),
        .wide(fu_wide),
        .value16(fu_value16),
        .shift_c(fu_shift_c),
        .result(fu_result),
        .v(fu_v),
        .h(fu_h),
        .n(fu_n),
        .z(fu_z),
        .c(fu_c),
        .we_v(fu_we_v),
        .we_h(fu_we_h),
        .we_c(fu_we_c)
    );

    // Bus address phase capture; write data arrives one cycle later.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
        end
    end

    // Read data is selected at the address phase; unmapped reads give zero.
    always @* begin
        next_rdata = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                `CRF_OFS_INDEX: next_rdata = {16'h0000, index_base};
                `CRF_OFS_STACK: next_rdata = {16'h0000, stack_top_ptr};
                `CRF_OFS_FETCH: next_rdata = {16'h0000, fetch_location};
                `CRF_OFS_FLAGS: next_rdata = {24'h000000, flags_word};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // Read data register, stable through the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Reset vector fetch sequencer.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_VEC_HI;
            vec_addr <= `CRF_VECTOR_HI;
        end else begin
            case (state)
                ST_VEC_HI: begin
                    if (vec_valid) begin
                        state <= ST_VEC_LO;
                        vec_addr <= `CRF_VECTOR_LO;
                    end
                end
                ST_VEC_LO: begin
                    if (vec_valid) begin
                        state <= ST_RUN;
                        vec_addr <= `CRF_VECTOR_HI;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_VEC_HI;
                    vec_addr <= `CRF_VECTOR_HI;
                end
            endcase
        end
    end

    // Fetch location: vector load, then flow changes or sequential steps.
    always @* begin
        next_fetch = fetch_location;
        if (wr_fetch) begin
            next_fetch = hwdata[15:0];
        end else begin
            case (state)
                ST_VEC_HI: begin
                    if (vec_valid) begin
                        next_fetch = {vec_data, fetch_location[7:0]};
                    end
                end
                ST_VEC_LO: begin
                    if (vec_valid) begin
                        next_fetch = {fetch_location[15:8], vec_data};
                    end
                end
                ST_RUN: begin
                    if (flow_load) begin
                        next_fetch = flow_target;
                    end else if (fetch_step) begin
                        next_fetch = fetch_location + 16'h0001;
                    end
                end
                default: begin
                    next_fetch = fetch_location;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_location <= `CRF_FETCH_RESET;
        end else begin
            fetch_location <= next_fetch;
        end
    end

    // Stack pointer updates; a bus write takes precedence.
    always @* begin
        next_stack = stack_top_ptr;
        if (wr_stack) begin
            next_stack = hwdata[15:0];
        end else if (sp_load16) begin
            next_stack = sp_data16;
        end else if (sp_adjust) begin
            next_stack = stack_top_ptr + {{8{sp_imm8[7]}}, sp_imm8};
        end else if (sp_low_restore) begin
            next_stack = {stack_top_ptr[15:8],
                `CRF_STACK_LOW_RESTORE};
        end else if (sp_push) begin
            next_stack = stack_top_ptr - 16'h0001;
        end else if (sp_pull) begin
            next_stack = stack_top_ptr + 16'h0001;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_top_ptr <= `CRF_STACK_RESET;
        end else begin
            stack_top_ptr <= next_stack;
        end
    end

    // Index pointer updates; low-byte loads leave the upper byte alone.
    always @* begin
        next_upper = pointer_upper_byte;
        next_low = pointer_low_byte;
        if (wr_index) begin
            next_upper = hwdata[15:8];
            next_low = hwdata[7:0];
        end else if (idx_load16) begin
            next_upper = idx_data16[15:8];
            next_low = idx_data16[7:0];
        end else if (idx_load_low) begin
            next_low = idx_low_data;
        end else if (idx_post_inc) begin
            {next_upper, next_low} = index_base + 16'h0001;
        end
    end

    // Upper byte is cleared by reset.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pointer_upper_byte <= `CRF_UPPER_RESET;
        end else begin
            pointer_upper_byte <= next_upper;
        end
    end

    // Low byte has no reset and keeps its contents across one.
    always @(posedge hclk) begin
        pointer_low_byte <= next_low;
    end

    // Flag register: bus write, then flags transfer, mask ops, ALU results.
    always @* begin
        next_flags = flags_store;
        if (wr_flags) begin
            next_flags = hwdata[7:0];
        end else if (flags_from_accum_op) begin
            next_flags = accum_data;
        end else begin
            if (fu_kind != `CRF_FU_NONE) begin
                next_flags[`CRF_BIT_N] = fu_n;
                next_flags[`CRF_BIT_Z] = fu_z;
                if (fu_we_v) begin
                    next_flags[`CRF_BIT_V] = fu_v;
                end
                if (fu_we_h) begin
                    next_flags[`CRF_BIT_H] = fu_h;
                end
                if (fu_we_c) begin
                    next_flags[`CRF_BIT_C] = fu_c;
                end
            end
            if (mask_clear_op) begin
                next_flags[`CRF_BIT_I] = 1'b0;
            end
            if (stack_done) begin
                next_flags[`CRF_BIT_I] = 1'b1;
            end
        end
        next_flags = next_flags | `CRF_FIXED_ONES;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_store <= `CRF_FLAGS_RESET;
        end else begin
            flags_store <= next_flags;
        end
    end

    // Inhibit one boundary after the mask drops; a new drop wins.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_inhibit <= 1'b0;
        end else if (mask_dropping) begin
            mask_inhibit <= 1'b1;
        end else if (insn_boundary) begin
            mask_inhibit <= 1'b0;
        end
    end

    // Registered result of the flag unit for the datapath.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alu_result <= 8'h00;
        end else if (fu_kind != `CRF_FU_NONE) begin
            alu_result <= fu_result;
        end
    end
endmodule

// ### rtl/crf_defines.vh
// Constants shared by the processor register file and its flag unit.
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH
// Register byte offsets on the bus.
`define CRF_OFS_INDEX 8'h00
`define CRF_OFS_STACK 8'h04
`define CRF_OFS_FETCH 8'h08
`define CRF_OFS_FLAGS 8'h0c
// Reset values, the fixed flag ones and the stack low-byte restore value.
`define CRF_UPPER_RESET 8'h00
`define CRF_STACK_RESET 16'h00ff
`define CRF_FLAGS_RESET 8'h68
`define CRF_FETCH_RESET 16'h0000
`define CRF_FIXED_ONES 8'h60
`define CRF_STACK_LOW_RESTORE 8'hff
// Reset vector locations.
`define CRF_VECTOR_HI 16'hfffe
`define CRF_VECTOR_LO 16'hffff
// Flag bit positions.
`define CRF_BIT_V 7
`define CRF_BIT_H 4
`define CRF_BIT_I 3
`define CRF_BIT_N 2
`define CRF_BIT_Z 1
`define CRF_BIT_C 0
// Flag update kinds.
`define CRF_FU_NONE 3'h0
`define CRF_FU_ADD 3'h1
`define CRF_FU_ADC 3'h2
`define CRF_FU_SUB 3'h3
`define CRF_FU_SBC 3'h4
`define CRF_FU_LOGIC 3'h5
`define CRF_FU_SHIFT 3'h6
`define CRF_FU_DECADJ 3'h7
`endif

// ### rtl/crf_flag_unit.v
// Flag and result computation for arithmetic, logic, load and decimal adjust.
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_flag_unit (
    input wire [2:0] kind,
    input wire [7:0] opa,
    input wire [7:0] opb,
    input wire cin,
    input wire hin,
    input wire wide,
    input wire [15:0] value16,
    input wire shift_c,
    output reg [7:0] result,
    output reg v,
    output reg h,
    output reg n,
    output reg z,
    output reg c,
    output reg we_v,
    output reg we_h,
    output reg we_c
);
    reg [8:0] sum;
    reg [4:0] half;
    reg [7:0] corr;
    reg cy;

    // Computes the result and the new flag values for one operation.
    always @* begin
        sum = 9'h000;
        half = 5'h00;
        corr = 8'h00;
        cy = 1'b0;
        result = opa;
        v = 1'b0;
        h = 1'b0;
        c = 1'b0;
        we_v = 1'b0;
        we_h = 1'b0;
        we_c = 1'b0;
        case (kind)
            `CRF_FU_ADD, `CRF_FU_ADC: begin
                cy = (kind == `CRF_FU_ADC) ? cin : 1'b0;
                sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cy};
                half = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cy};
                result = sum[7:0];
                v = (opa[7] == opb[7]) && (sum[7] != opa[7]);
                h = half[4];
                c = sum[8];
                we_v = 1'b1;
                we_h = 1'b1;
                we_c = 1'b1;
            end
            `CRF_FU_SUB, `CRF_FU_SBC: begin
                cy = (kind == `CRF_FU_SBC) ? cin : 1'b0;
                sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cy};
                result = sum[7:0];
                v = (opa[7] != opb[7]) && (sum[7] != opa[7]);
                c = sum[8];
                we_v = 1'b1;
                we_c = 1'b1;
            end
            `CRF_FU_LOGIC: begin
                we_v = 1'b1; // Logic results, loads and stores clear overflow.
            end
            `CRF_FU_SHIFT: begin
                c = shift_c;
                v = (wide ? value16[15] : opa[7]) ^ shift_c;
                we_v = 1'b1;
                we_c = 1'b1;
            end
            `CRF_FU_DECADJ: begin
                // Low digit correction from half carry, high from carry.
                if (hin || (opa[3:0] > 4'h9)) begin
                    corr[3:0] = 4'h6;
                end
                if (cin || (opa > 8'h99)) begin
                    corr[7:4] = 4'h6;
                end
                sum = {1'b0, opa} + {1'b0, corr};
                result = sum[7:0];
                c = cin || (opa > 8'h99);
                we_c = 1'b1;
            end
            default: begin
                result = opa;
            end
        endcase
        n = (wide && kind == `CRF_FU_LOGIC) ? value16[15] : result[7];
        if (wide && kind == `CRF_FU_LOGIC) begin
            z = (value16 == 16'h0000);
        end else begin
            z = (result == 8'h00);
        end
    end
endmodule

// ### sim/crf_register_file_sva.sv
// Port assertions for the processor register file.
`timescale 1ns/1ps
module crf_register_file_sva (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic vec_req,
    input logic [15:0] vec_addr,
    input logic vec_valid,
    input logic [7:0] vec_data,
    input logic core_run,
    input logic fetch_step,
    input logic flow_load,
    input logic [15:0] flow_target,
    input logic [15:0] fetch_location,
    input logic idx_load16,
    input logic idx_load_low,
    input logic [7:0] idx_low_data,
    input logic idx_post_inc,
    input logic [15:0] index_base,
    input logic sp_load16,
    input logic sp_adjust,
    input logic [7:0] sp_imm8,
    input logic sp_low_restore,
    input logic [15:0] stack_top_ptr,
    input logic [7:0] flags_word,
    input logic mask_clear_op,
    input logic flags_from_accum_op,
    input logic stack_done,
    input logic insn_boundary,
    input logic irq_pending,
    input logic irq_take
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic dp_wr;

    // Marks a bus write data phase, which beats the datapath update of the register it writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dp_wr <= 1'b0;
        else
            dp_wr <= hsel && hready && htrans[1] && hwrite;
    end

    // A mask drop by the datapath alone, away from a boundary.
    sequence s_drop;
        mask_clear_op && flags_word[3] && !stack_done && !insn_boundary &&
            !flags_from_accum_op && !dp_wr;
    endsequence
    // The low vector byte arriving.
    sequence s_vec_lo;
        vec_req && vec_valid && vec_addr == 16'hffff && !dp_wr;
    endsequence

    chk_fixed_ones: assert property (
        flags_word[6:5] == 2'b11) else $error("flag bits 6,5 not one");
    chk_take_cause: assert property (
        irq_take |-> insn_boundary && irq_pending && core_run &&
        !flags_word[3]) else $error("interrupt taken without cause");
    chk_mask_set: assert property (
        stack_done && !flags_from_accum_op && !dp_wr |=> flags_word[3])
        else $error("mask not set after stacking");
    chk_cli_holdoff: assert property (
        s_drop ##1 insn_boundary |-> !irq_take)
        else $error("interrupt right after mask drop");
    chk_stack_adjust: assert property (
        sp_adjust && !sp_load16 && !dp_wr |=> stack_top_ptr ==
        $past(stack_top_ptr) + 16'($signed($past(sp_imm8))))
        else $error("stack adjust wrong");
    chk_stack_restore: assert property (
        sp_low_restore && !sp_load16 && !sp_adjust && !dp_wr |=>
        stack_top_ptr[7:0] == 8'hff &&
        ((stack_top_ptr ^ $past(stack_top_ptr)) & 16'hff00) == 16'h0000)
        else $error("stack restore wrong");
    chk_low_only: assert property (
        idx_load_low && !idx_load16 && !idx_post_inc && !dp_wr |=>
        index_base == (($past(index_base) & 16'hff00) |
        {8'h00, $past(idx_low_data)})) else $error("low byte load wrong");
    chk_fetch_step: assert property (
        core_run && fetch_step && !flow_load && !dp_wr |=>
        fetch_location == $past(fetch_location) + 16'h0001)
        else $error("fetch step wrong");
    chk_flow_load: assert property (
        core_run && flow_load && !dp_wr |=>
        fetch_location == $past(flow_target)) else $error("flow load wrong");
    chk_vector_load: assert property (
        s_vec_lo |=> core_run && fetch_location[7:0] == $past(vec_data))
        else $error("vector load wrong");
endmodule

bind crf_register_file crf_register_file_sva u_sva (.*);

// ### sim/crf_vec_model.sv
// Sequencer stand-in that serves the two reset vector bytes.
`timescale 1ns/1ps
module crf_vec_model #(
    parameter [15:0] VECTOR = 16'h1234,
    parameter WAIT = 2
) (
    input wire hclk,
    input wire hresetn,
    input wire vec_req,
    input wire [15:0] vec_addr,
    output reg vec_valid,
    output reg [7:0] vec_data
);
    integer cnt;

    // Answers each byte after WAIT cycles; the data lines change between.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            vec_valid <= 1'b0;
            vec_data <= 8'h00;
        end else if (vec_req && !vec_valid && cnt >= WAIT) begin
            cnt <= 0;
            vec_valid <= 1'b1;
            vec_data <= vec_addr[0] ? VECTOR[7:0] : VECTOR[15:8];
        end else begin
            cnt <= vec_req ? cnt + 1 : 0;
            vec_valid <= 1'b0;
            vec_data <= ~vec_data;
        end
    end
endmodule

// ### sim/testbench.sv
// Bench for the register file, its bus port and datapath controls.
`timescale 1ns/1ps
module testbench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, fu_kind;
    logic vec_req, vec_valid, core_run, fetch_step, flow_load;
    logic [7:0] vec_data, sp_imm8, fu_opa, fu_opb, alu_result;
    logic [7:0] idx_low_data, flags_word, accum_data;
    logic [15:0] vec_addr, flow_target, fetch_location, idx_data16;
    logic [15:0] index_base, sp_data16, stack_top_ptr, fu_value16;
    logic idx_load16, idx_load_low, idx_post_inc, sp_load16, sp_adjust;
    logic sp_low_restore, sp_push, sp_pull, fu_wide, fu_shift_c;
    logic mask_clear_op, flags_from_accum_op, stack_done, insn_boundary;
    logic irq_pending, irq_take;
    int n_errors = 0;
    int check_count = 0;

    assign hready = hreadyout;
    crf_register_file DUT (.*);
    crf_vec_model #(.VECTOR(16'h1234), .WAIT(2)) u_vec (.*);

    // Makes the 25 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task test_done;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task clr;
        {fetch_step, flow_load, idx_load16, idx_load_low, idx_post_inc} <= '0;
        {sp_load16, sp_adjust, sp_low_restore, sp_push, sp_pull} <= '0;
        {mask_clear_op, flags_from_accum_op, stack_done} <= '0;
        insn_boundary <= 1'b0;
        fu_kind <= 3'h0;
    endtask

    // One clock with the pulses ending; updates have landed on return.
    task idle;
        @(posedge hclk);
        clr;
        #1;
    endtask

    task bus(input logic wr, input logic [31:0] a, wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    task alu(input logic [2:0] k, input logic [7:0] a, b);
        fu_kind <= k;
        fu_opa <= a;
        fu_opb <= b;
        idle;
    endtask

    task wait_run;
        while (core_run !== 1'b1) idle;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (4000) @(posedge hclk);
        n_errors++;
        $display("Error watchdog expired");
        test_done;
    end

    // Main sequence.
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, idx_data16, idx_low_data} <= '0;
        {sp_data16, sp_imm8, fu_opa, fu_opb, fu_wide, fu_value16} <= '0;
        {flow_target, fu_shift_c, accum_data, irq_pending} <= '0;
        hsize <= 3'h2;
        hresetn <= 1'b0;
        clr;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wait_run;
        check("fetch", fetch_location, 16'h1234);
        check("idle", {hresp, vec_req}, 2'b00);
        bus(0, 32'h08, 0);
        check("fetch rd", rd, 32'h1234);
        bus(0, 32'h04, 0);
        check("stack rst", rd, 32'h00ff);
        bus(0, 32'h0c, 0);
        check("flags rst", rd, 32'h68);
        check("upper rst", index_base[15:8], 8'h00);
        bus(0, 32'h20, 0);
        check("unmapped", rd, 32'h0);
        $display("test reset done");
        sp_adjust <= 1'b1;
        sp_imm8 <= 8'h80;
        idle;
        check("sp adj", stack_top_ptr, 16'h007f);
        sp_adjust <= 1'b1;
        sp_imm8 <= 8'h81;
        idle;
        check("sp adj2", stack_top_ptr, 16'h0000);
        sp_load16 <= 1'b1;
        sp_data16 <= 16'h1234;
        idle;
        sp_low_restore <= 1'b1;
        idle;
        check("sp rsp", stack_top_ptr, 16'h12ff);
        sp_push <= 1'b1;
        idle;
        check("sp push", stack_top_ptr, 16'h12fe);
        bus(1, 32'h04, 32'h0000abcd);
        bus(0, 32'h04, 0);
        check("sp bus", rd, 32'h0000abcd);
        bus(1, 32'h104, 32'h00005555);
        bus(0, 32'h04, 0);
        check("sp alias", rd, 32'h0000abcd);
        $display("test stack done");
        idx_load16 <= 1'b1;
        idx_data16 <= 16'ha5ff;
        idle;
        idx_post_inc <= 1'b1;
        idle;
        check("idx inc", index_base, 16'ha600);
        idx_load_low <= 1'b1;
        idx_low_data <= 8'h77;
        idle;
        check("idx low", index_base, 16'ha677);
        bus(0, 32'h00, 0);
        check("idx rd", rd, 32'ha677);
        fetch_step <= 1'b1;
        idle;
        fetch_step <= 1'b1;
        idle;
        check("step", fetch_location, 16'h1236);
        flow_load <= 1'b1;
        flow_target <= 16'h4000;
        fetch_step <= 1'b1;
        idle;
        check("flow", fetch_location, 16'h4000);
        $display("test pointers done");
        bus(1, 32'h0c, 32'h0);
        bus(0, 32'h0c, 0);
        check("flags wr", rd, 32'h60);
        alu(3'h1, 8'h7f, 8'h01);
        check("add ovf", flags_word, 8'hf4);
        alu(3'h1, 8'h80, 8'h80);
        check("add zero", flags_word, 8'he3);
        alu(3'h3, 8'h00, 8'h01);
        check("sub", flags_word & 8'h87, 8'h05);
        alu(3'h4, 8'h00, 8'h00);
        check("sbc", alu_result, 8'hff);
        alu(3'h2, 8'h01, 8'h01);
        check("adc", alu_result, 8'h03);
        fu_wide <= 1'b1;
        alu(3'h5, 8'h80, 8'h00);
        check("ld16 z", flags_word, 8'h62);
        fu_wide <= 1'b0;
        fu_shift_c <= 1'b1;
        alu(3'h6, 8'h00, 8'h00);
        check("shift", flags_word, 8'he3);
        alu(3'h1, 8'h09, 8'h08);
        alu(3'h7, 8'h11, 8'h00);
        check("dec adj", alu_result, 8'h17);
        $display("test flags done");
        irq_pending <= 1'b1;
        insn_boundary <= 1'b1;
        #1 check("take", irq_take, 1'b1);
        idle;
        stack_done <= 1'b1;
        idle;
        check("mask set", flags_word[3], 1'b1);
        insn_boundary <= 1'b1;
        #1 check("masked", irq_take, 1'b0);
        idle;
        mask_clear_op <= 1'b1;
        idle;
        insn_boundary <= 1'b1;
        #1 check("holdoff", irq_take, 1'b0);
        idle;
        insn_boundary <= 1'b1;
        #1 check("retake", irq_take, 1'b1);
        idle;
        irq_pending <= 1'b0;
        flags_from_accum_op <= 1'b1;
        idle;
        check("accum", flags_word, 8'h60);
        $display("test interrupt done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1 check("idx rst", index_base, 16'h0077);
        check("sp rst", stack_top_ptr, 16'h00ff);
        hresetn <= 1'b1;
        wait_run;
        check("fetch2", fetch_location, 16'h1234);
        $display("test second reset done");
        test_done;
    end
endmodule
